// file: card_event_pkg.sv
// Functional notes
// - The routing field picks no line for 0000, line 1 for 0001, the management interrupt for 0010, and line n for each value n from 3 to 15.
// - With field 0000 and the diagnostic routing bit set, events go to the PCI interrupt whatever the PCI enable bit says.
// - With field 0000 and the diagnostic bit clear, no legacy line is used and events reach PCI only if the PCI enable bit is set.
// - The card-detect mask lets any change on either detect line raise an event; it resets to off.
// - The ready mask lets each rising edge of ready raise an event on a memory card only; it resets to off.
// - The battery-low mask lets a battery warning raise an event on a memory card only; it resets to off.
// - The battery-dead mask lets battery dead (memory card) or the status-change pin (I/O card) raise an event; it resets to off.
// - A host memory or I/O cycle through a window whose enable bit is 0 is never acknowledged.
// - All windows are disabled after reset until software enables them.
// - Bit 7 enables I/O window 1 and bit 6 enables I/O window 0.
// - Bit n enables memory window n for n from 0 to 4.
// - Bit 5 of the window enable register reads 0 and ignores writes.
// - A masked source's flag reads 0; an enabled source sets its flag when it becomes active.
// - With the PCI enable bit set, events are delivered to the PCI interrupt.
// - Flags clear either on a read of the flag register or by writing 1 per flag, as the clear-mode bit selects.
package card_event_pkg;
   localparam logic [7:0] FLAG_OFFSET = 8'h04;
   localparam logic [7:0] IRQ_CONFIG_OFFSET = 8'h05;
   localparam logic [7:0] WINDOW_ENABLE_OFFSET = 8'h06;
   localparam logic [7:0] IRQ_CONFIG_RESET = 8'h00;
   localparam logic [7:0] WINDOW_ENABLE_RESET = 8'h00;
   localparam logic [7:0] WINDOW_ENABLE_WMASK = 8'hDF;
   localparam logic [3:0] FLAG_RESET = 4'h0;
   localparam int ROUTE_HI = 7;
   localparam int ROUTE_LO = 4;
   localparam int DETECT_BIT = 3;
   localparam int READY_BIT = 2;
   localparam int BATLOW_BIT = 1;
   localparam int BATDEAD_BIT = 0;
   localparam int IO_ONE_BIT = 7;
   localparam int IO_ZERO_BIT = 6;
   localparam int MEM_WINDOWS = 5;
   localparam logic [3:0] ROUTE_NONE = 4'h0;
   localparam logic [3:0] ROUTE_SMI = 4'h2;
endpackage

// file: card_event_irq_and_window_enable.sv
`timescale 1ns/1ns
`default_nettype none
module card_event_irq_and_window_enable
   import card_event_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   input wire logic diagEventToPci,
   input wire logic eventToPciEnable,
   input wire logic flagClearByWrite,
   input wire logic ioCardInstalled,
   input wire logic cardDetectOne,
   input wire logic cardDetectTwo,
   input wire logic cardReady,
   input wire logic batteryLow,
   input wire logic batteryDead,
   input wire logic cardStatusChangePin,
   input wire logic [1:0] ioWindowHit,
   input wire logic [4:0] memWindowHit,
   output logic [1:0] ioWindowAck,
   output logic [4:0] memWindowAck,
   output logic [15:0] legacyIrq,
   output logic systemManagementIrq,
   output logic pciIrq
);
   logic [7:0] irqConfig_q, irqConfig_d;
   logic [7:0] windowEnable_q, windowEnable_d;
   logic [3:0] flags_q, flags_d;
   logic [1:0] detect_q, detect_d;
   logic ready_q, ready_d;
   logic [3:0] raise, clearMask, maskBits;
   logic [3:0] routeSelect;
   logic anyFlag;
   logic [15:0] legacyDecode;

   logic [1:0] detectNow;
   logic detectChange;
   logic readyRise;
   logic deadSource;
   logic flagRead;
   logic flagWrite;
   logic configWrite;
   logic windowWrite;
   logic routeIsNone;
   logic routeIsSmi;
   // window byte as seen by the host
   logic [7:0] windowReadback;

   // mask bits and routing field of the config register
   assign maskBits = irqConfig_q[DETECT_BIT:BATDEAD_BIT];
   assign routeSelect = irqConfig_q[ROUTE_HI:ROUTE_LO];

   // register strobes for the mapped offsets, read and write for the flag offset
   assign flagRead = regRead && (regAddr == FLAG_OFFSET);
   assign flagWrite = regWrite && (regAddr == FLAG_OFFSET);
   assign configWrite = regWrite && (regAddr == IRQ_CONFIG_OFFSET);
   assign windowWrite = regWrite && (regAddr == WINDOW_ENABLE_OFFSET);

   // raw event sources before masking
   assign detectNow = {cardDetectTwo, cardDetectOne};
   assign detectChange = (detectNow != detect_q);
   assign readyRise = cardReady & ~ready_q;
   assign deadSource = ioCardInstalled ? cardStatusChangePin : batteryDead;

   // masked event raise; ready and battery low only for memory cards
   always_comb
   begin
      raise = FLAG_RESET;
      if (maskBits[DETECT_BIT] && detectChange)
      begin
         raise[DETECT_BIT] = 1'b1;
      end
      if (maskBits[READY_BIT] && !ioCardInstalled && readyRise)
      begin
         raise[READY_BIT] = 1'b1;
      end
      if (maskBits[BATLOW_BIT] && !ioCardInstalled && batteryLow)
      begin
         raise[BATLOW_BIT] = 1'b1;
      end
      if (maskBits[BATDEAD_BIT] && deadSource)
      begin
         raise[BATDEAD_BIT] = 1'b1;
      end
   end

   // clear strobes, method picked by the clear-mode input
   always_comb
   begin
      clearMask = FLAG_RESET;
      if (flagClearByWrite)
      begin
         if (flagWrite)
         begin
            clearMask = regWdata[DETECT_BIT:BATDEAD_BIT];
         end
      end
      else
      begin
         if (flagRead)
         begin
            clearMask = ~FLAG_RESET;
         end
      end
   end

   // next values of config, window, flag and history registers
   always_comb
   begin
      irqConfig_d = irqConfig_q;
      windowEnable_d = windowEnable_q;
      detect_d = detectNow;
      ready_d = cardReady;
      // set wins over clear; masked sources forced to zero
      flags_d = ((flags_q & ~clearMask) | raise) & maskBits;
      if (configWrite)
      begin
         irqConfig_d = regWdata;
      end
      if (windowWrite)
      begin
         windowEnable_d = regWdata & WINDOW_ENABLE_WMASK;
      end
   end

   // history registers start at zero, masks are off then
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         irqConfig_q <= IRQ_CONFIG_RESET;
         windowEnable_q <= WINDOW_ENABLE_RESET;
         flags_q <= FLAG_RESET;
         detect_q <= 2'h0;
         ready_q <= 1'b0;
      end
      else
      begin
         irqConfig_q <= irqConfig_d;
         windowEnable_q <= windowEnable_d;
         flags_q <= flags_d;
         detect_q <= detect_d;
         ready_q <= ready_d;
      end
   end

   // bit 5 is never stored, masked again on the way out
   assign windowReadback = windowEnable_q & WINDOW_ENABLE_WMASK;

   // combinational read mux, unmapped offsets read zero
   always_comb
   begin
      case (regAddr)
         FLAG_OFFSET: regRdata = 8'(flags_q);
         IRQ_CONFIG_OFFSET: regRdata = irqConfig_q;
         WINDOW_ENABLE_OFFSET: regRdata = windowReadback;
         default: regRdata = 8'h00;
      endcase
   end

   // window acknowledge gating; i/o enables sit above the memory ones
   genvar g;
   generate
      for (g = 0; g <= IO_ONE_BIT - IO_ZERO_BIT; g++)
      begin : ioGate
         assign ioWindowAck[g] = ioWindowHit[g] & windowEnable_q[IO_ZERO_BIT + g];
      end
      for (g = 0; g < MEM_WINDOWS; g++)
      begin : memGate
         assign memWindowAck[g] = memWindowHit[g] & windowEnable_q[g];
      end
   endgenerate

   // interrupt outputs follow the registered flags
   assign anyFlag = |flags_q;
   assign routeIsNone = (routeSelect == ROUTE_NONE);
   assign routeIsSmi = (routeSelect == ROUTE_SMI);

   // legacy line decode, none for field zero or the management code
   always_comb
   begin
      legacyDecode = 16'h0000;
      if (!routeIsNone && !routeIsSmi)
      begin
         legacyDecode[routeSelect] = anyFlag;
      end
   end

   assign legacyIrq = legacyDecode;

   always_comb
   begin
      systemManagementIrq = 1'b0;
      if (routeIsSmi && anyFlag)
      begin
         systemManagementIrq = 1'b1;
      end
   end

   // pci path: enable bit, or diagnostic bit with field zero
   always_comb
   begin
      pciIrq = 1'b0;
      if (anyFlag && eventToPciEnable)
      begin
         pciIrq = 1'b1;
      end
      if (anyFlag && routeIsNone && diagEventToPci)
      begin
         pciIrq = 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: card_event_sva.sv
`timescale 1ns/1ns
`default_nettype none
module card_event_sva
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   input wire logic [1:0] ioWindowHit,
   input wire logic [4:0] memWindowHit,
   input wire logic [1:0] ioWindowAck,
   input wire logic [4:0] memWindowAck,
   input wire logic [15:0] legacyIrq,
   input wire logic systemManagementIrq,
   input wire logic pciIrq
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   chk_io_gate: assert property (!(ioWindowAck & ~ioWindowHit))
      else $error("io ack");
   chk_mem_gate: assert property (!(memWindowAck & ~memWindowHit))
      else $error("mem ack");
   chk_line_zero: assert property (!legacyIrq[0])
      else $error("line 0");
   chk_one_route: assert property ($onehot0({legacyIrq, systemManagementIrq}))
      else $error("two routes");
   chk_reset_closed: assert property ($past(rst) |-> !{ioWindowAck, memWindowAck})
      else $error("open window");
   chk_win_store: assert property (regWrite && regAddr == 8'h06 ##1 regAddr == 8'h06
      |-> regRdata == ($past(regWdata) & 8'hDF)) else $error("window write");
   chk_cfg_store: assert property (regWrite && regAddr == 8'h05 ##1 regAddr == 8'h05
      |-> regRdata == $past(regWdata)) else $error("config write");
   chk_bit_five: assert property (regAddr == 8'h06 |-> !regRdata[5])
      else $error("bit 5");
   cover property (systemManagementIrq);
   cover property (pciIrq && legacyIrq == 16'h0000);
   cover property (|ioWindowAck);
endmodule
bind card_event_irq_and_window_enable card_event_sva chk (.*);
`default_nettype wire

// file: card_model.sv
`timescale 1ns/1ns
`default_nettype none
module card_model
(
   input wire logic core_clk,
   input wire logic [5:0] lineCmd,
   output logic [5:0] cardLines
);
   // detect, detect, ready, low, dead, change pin; move just after the edge
   always_ff @(posedge core_clk) cardLines <= lineCmd;
endmodule
`default_nettype wire

// file: card_event_irq_and_window_enable_bench.sv
`timescale 1ns/1ns
`default_nettype none
module card_event_irq_and_window_enable_bench;
   logic core_clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
   logic diagEventToPci = 1'b0, eventToPciEnable = 1'b0;
   logic flagClearByWrite = 1'b0, ioCardInstalled = 1'b0;
   logic [7:0] regAddr = 8'h06, regWdata = 8'h00, d;
   logic [5:0] lineCmd = 6'h00;
   logic [1:0] ioWindowHit = 2'h3;
   logic [4:0] memWindowHit = 5'h1F;
   wire logic [7:0] regRdata;
   wire logic [5:0] cardLines;
   wire logic [1:0] ioWindowAck;
   wire logic [4:0] memWindowAck;
   wire logic [15:0] legacyIrq;
   wire logic systemManagementIrq, pciIrq;
   int error_cnt = 0, comparisons = 0;
   always #25 core_clk = ~core_clk;
   card_model PM (.core_clk, .lineCmd, .cardLines);
   card_event_irq_and_window_enable DUT (.*,
      .cardDetectOne(cardLines[5]), .cardDetectTwo(cardLines[4]), .cardReady(cardLines[3]),
      .batteryLow(cardLines[2]), .batteryDead(cardLines[1]), .cardStatusChangePin(cardLines[0]));
   task automatic chk(input logic [15:0] got, exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, v);
      @(negedge core_clk);
      regAddr = a;
      regWdata = v;
      regWrite = 1'b1;
      @(negedge core_clk);
      regWrite = 1'b0;
   endtask
   function automatic logic [15:0] route(input int r);
      return (r == 1 || r > 2) ? 16'h0001 << r : 16'h0000;
   endfunction
   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #100000;
      error_cnt++;
      report_and_stop;
   end
   initial
   begin
      void'($urandom(76));
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      #1;
      chk({regRdata, 1'b0, ioWindowAck, memWindowAck}, 16'h0000);
      for (int i = 0; i < 12; i++)
      begin
         d = i ? 8'($urandom) : 8'hFF;
         wr(8'h06, d);
         ioWindowHit = 2'($urandom);
         memWindowHit = 5'($urandom);
         #1;
         chk(regRdata, d & 8'hDF);
         chk({ioWindowAck, memWindowAck}, {ioWindowHit & d[7:6], memWindowHit & d[4:0]});
      end
      // all sources active with masks off, then only the dead source unmasked
      wr(8'h05, 8'h30);
      lineCmd = 6'h3F;
      repeat (2) @(negedge core_clk);
      chk(legacyIrq, 16'h0000);
      wr(8'h05, 8'h31);
      @(negedge core_clk);
      chk(legacyIrq, 16'h0008);
      lineCmd = 6'h00;
      for (int r = 0; r < 16; r++)
      begin
         diagEventToPci = 1'($urandom);
         eventToPciEnable = 1'($urandom);
         wr(8'h05, {r[3:0], 4'h4});
         lineCmd = 6'h08;
         repeat (2) @(negedge core_clk);
         chk(legacyIrq, route(r));
         chk({systemManagementIrq, pciIrq}, {r == 2, eventToPciEnable | (r == 0 & diagEventToPci)});
         lineCmd = 6'h00;
         regAddr = 8'h04;
         regRead = 1'b1;
         @(negedge core_clk);
         regRead = 1'b0;
         chk(legacyIrq | {systemManagementIrq, pciIrq}, 16'h0000);
      end
      // write-one clear mode with detect and battery-low sources
      flagClearByWrite = 1'b1;
      wr(8'h05, 8'h3B);
      lineCmd = 6'h24;
      repeat (2) @(negedge core_clk);
      regAddr = 8'h04;
      #1;
      chk(regRdata, 8'h0A);
      chk(legacyIrq, 16'h0008);
      lineCmd = 6'h20;
      wr(8'h04, 8'h0A);
      #1;
      chk(regRdata, 8'h00);
      // i/o card: change pin counts, battery low does not
      ioCardInstalled = 1'b1;
      lineCmd = 6'h25;
      repeat (2) @(negedge core_clk);
      #1;
      chk(regRdata, 8'h01);
      report_and_stop;
   end
endmodule
`default_nettype wire
